/* pdr_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module pdr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic flush_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff, rd_ff;
    logic [AW:0] cnt_ff;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;

    // Honest flags straight from the occupancy
    // Count is one bit wider than the pointers, so full must compare at that width
    assign in_ready_out = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_ff != '0);
    assign out_data_out = mem[rd_ff];

    // Pointers and count; flush discards a broken frame
    always_ff @(posedge clk_in) begin
        if (rst_in || flush_in) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) wr_ff <= wr_ff + 1'b1;
            if (pop) rd_ff <= rd_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage needs no reset
    always_ff @(posedge clk_in) begin
        if (push) mem[wr_ff] <= in_data_in;
    end
endmodule
`default_nettype wire

/* pdr_kind_map.sv */
`timescale 1ns/10ps
`default_nettype none
module pdr_kind_map (
    // Frame kind and enables
    input wire logic [2:0] kind_in,
    input wire logic [7:0] det_en_in,
    // Result
    output logic enabled_out
);
    // Each kind code selects its own enable bit; codes above cable reset are never accepted
    wire [2:0] bit_sel = kind_in;
    assign enabled_out = (kind_in <= pdr_pkg::KIND_CABLE_RESET) && det_en_in[bit_sel];
endmodule
`default_nettype wire

/* pdr_phy_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pdr_phy_model (
    // Clock
    input wire logic clk_in,
    // Byte stream toward the block
    output logic start_out,
    output logic [2:0] kind_out,
    output logic valid_out,
    output logic [7:0] data_out,
    input wire logic ready_in,
    output logic end_out,
    output logic good_out
);
    int timeouts = 0; // Bytes pushed only after the wait bound ran out
    // Idle stream: data shows the inverse of the last byte, not a stale copy
    initial begin
        start_out = 1'b0;
        kind_out = 3'h7;
        valid_out = 1'b0;
        data_out = 8'h00;
        end_out = 1'b0;
        good_out = 1'b0;
    end

    // One frame: start with kind, bytes held until taken, then end
    task send_frame(input logic [2:0] kind, input int nbytes, input logic [7:0] base,
                    input logic good, input int gap);
        int i;
        int n;
        @(posedge clk_in);
        #1;
        start_out = 1'b1;
        kind_out = kind;
        good_out = good;
        @(posedge clk_in);
        #1;
        start_out = 1'b0;
        kind_out = ~kind; // Kind only qualifies the start pulse
        for (i = 0; i < nbytes; i++) begin
            valid_out = 1'b1;
            data_out = base + i[7:0];
            n = 0;
            while (ready_in !== 1'b1 && n < 200) begin
                @(posedge clk_in);
                #1;
                n++;
            end
            if (n >= 200) timeouts++;
            @(posedge clk_in);
            #1;
            // Without a gap valid stays up, so it never toggles twice in one step
            if (gap > 0) begin
                valid_out = 1'b0;
                data_out = ~data_out;
                repeat (gap) @(posedge clk_in); // Slow partner leaves gaps
                #1;
            end
        end
        if (valid_out) begin
            valid_out = 1'b0;
            data_out = ~data_out;
        end
        end_out = 1'b1;
        @(posedge clk_in);
        #1;
        end_out = 1'b0;
    endtask
endmodule
`default_nettype wire

/* pdr_pkg.sv */
package pdr_pkg;
    // Register offsets on the byte-wide register port
    localparam logic [7:0] ADDR_HDR_CFG = 8'h2e;
    localparam logic [7:0] ADDR_DET_EN = 8'h2f;
    localparam logic [7:0] ADDR_RX_LEN = 8'h30;
    localparam logic [7:0] ADDR_RX_KIND = 8'h31;
    localparam logic [7:0] ADDR_RX_HDR_LO = 8'h32;
    localparam logic [7:0] ADDR_RX_HDR_HI = 8'h33;
    localparam logic [7:0] ADDR_RX_PAYLOAD_FIRST = 8'h34;
    localparam logic [7:0] ADDR_RX_PAYLOAD_LAST = 8'h4f;
    // Reset values
    localparam logic [7:0] HDR_CFG_RESET = 8'h02;
    localparam logic [7:0] DET_EN_RESET = 8'h00;
    localparam logic [7:0] RX_ZERO = 8'h00;
    // Field masks
    localparam logic [7:0] HDR_CFG_WMASK = 8'h1f;
    localparam logic [7:0] DET_EN_WMASK = 8'h7f;
    // Header configuration field positions
    localparam int HDR_POWER_ROLE_BIT = 0;
    localparam int HDR_REV_LSB = 1;
    localparam int HDR_DATA_ROLE_BIT = 3;
    localparam int HDR_CABLE_PLUG_BIT = 4;
    // Detect enable positions
    localparam int DET_HARD_RESET_BIT = 5;
    localparam int DET_CABLE_RESET_BIT = 6;
    // Frame kinds
    localparam logic [2:0] KIND_SOP = 3'h0;
    localparam logic [2:0] KIND_DBG_FAR = 3'h4;
    localparam logic [2:0] KIND_HARD_RESET = 3'h5;
    localparam logic [2:0] KIND_CABLE_RESET = 3'h6;
    // Buffer sizing and byte counts
    localparam int PAYLOAD_BYTES = 28;
    localparam logic [7:0] RX_OVERHEAD = 8'h03;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
endpackage

/* pdr_rx_regs.sv */
// Contract
// - Reserved header bits written zero, ignored
// - Bits set plug origin, data, power role
// - Revision field codes, resets to 2.0
// - Fast swap, chunking kept at 2.0; code reports both supported at every revision
// - Seven per-kind detect enables gate reception
// - Hard reset clears detect enables
// - Disconnect leaves detect enables alone
// - Hard reset or disconnect zero count; code loads the new count instead if a message commits in the same cycle
// - Clearing message alert zeroes count
// - Count is payload bytes plus three
// - Frame kind codes, upper bits zero
// - Header low then high byte
// - Payload bytes follow header registers
`timescale 1ns/10ps
`default_nettype none
module pdr_rx_regs (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // Receive stream from the physical layer
    input wire logic rx_start_in,
    input wire logic [2:0] rx_kind_in,
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_data_in,
    output logic rx_ready_out,
    input wire logic rx_end_in,
    input wire logic rx_good_in,
    // Link events
    input wire logic hard_reset_rx_in,
    input wire logic hard_reset_tx_in,
    input wire logic disconnect_in,
    input wire logic rx_message_alert_clear_in,
    // Status to the rest of the device
    output logic rx_message_alert_out,
    output logic hard_reset_seen_out,
    output logic cable_reset_seen_out,
    output logic [7:0] hdr_cfg_out,
    output logic [7:0] det_en_out,
    output logic fast_swap_supported_out,
    output logic chunked_ext_supported_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_DRAIN} pdr_state_t;
    pdr_state_t state_ff, nxt_state;
    logic [7:0] hdr_cfg_ff, det_en_ff, rx_len_ff, rx_kind_ff, hdr_lo_ff, hdr_hi_ff;
    logic [7:0] payload_ff [pdr_pkg::PAYLOAD_BYTES];
    logic [2:0] cur_kind_ff;
    logic [7:0] wcnt_ff, dcnt_ff;
    logic [7:0] stg_lo_ff, stg_hi_ff;
    logic alert_ff, hr_seen_ff, cr_seen_ff, overflow_ff;
    logic f_valid, f_ready, f_in_ready;
    logic [7:0] f_data;
    logic kind_enabled;

    // Frame filter and stream acceptance
    pdr_kind_map u_map (
        .kind_in(rx_start_in ? rx_kind_in : cur_kind_ff),
        .det_en_in(det_en_ff),
        .enabled_out(kind_enabled)
    );

    wire accept_start = rx_start_in && kind_enabled && (state_ff == ST_IDLE);
    wire is_hard = rx_start_in && (rx_kind_in == pdr_pkg::KIND_HARD_RESET) && kind_enabled;
    wire is_cable = rx_start_in && (rx_kind_in == pdr_pkg::KIND_CABLE_RESET) && kind_enabled;
    wire is_msg_kind = rx_kind_in <= pdr_pkg::KIND_DBG_FAR;
    wire in_frame = (state_ff == ST_FRAME);
    wire hr_event = is_hard || hard_reset_rx_in || hard_reset_tx_in;

    // Bytes land in the FIFO; while a committed message waits, a new frame is taken until the 16-entry FIFO fills, then stalls
    assign rx_ready_out = in_frame && f_in_ready;
    wire f_push = rx_valid_in && rx_ready_out;

    pdr_fifo #(.WIDTH(pdr_pkg::FIFO_WIDTH), .DEPTH(pdr_pkg::FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .flush_in(hr_event || disconnect_in),
        .in_valid_in(f_push),
        .in_ready_out(f_in_ready),
        .in_data_in(rx_data_in),
        .out_valid_out(f_valid),
        .out_ready_in(f_ready),
        .out_data_out(f_data)
    );

    // Drain only while no unread message holds the buffer
    assign f_ready = !alert_ff;
    wire f_pop = f_valid && f_ready;
    wire good_end = (state_ff == ST_DRAIN) && !f_valid && rx_good_in && !overflow_ff && (dcnt_ff >= 8'h02);
    wire bad_end = (state_ff == ST_DRAIN) && !f_valid && (!rx_good_in || overflow_ff || dcnt_ff < 8'h02);

    // Frame sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (accept_start && !is_hard && !is_cable && is_msg_kind) nxt_state = ST_FRAME;
            end
            ST_FRAME: begin
                if (rx_end_in) nxt_state = ST_DRAIN;
            end
            ST_DRAIN: begin
                if (good_end || bad_end) nxt_state = ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (hr_event || disconnect_in) nxt_state = ST_IDLE;
    end

    // Register writes and decode
    wire wr_hdr = reg_wr_in && (reg_addr_in == pdr_pkg::ADDR_HDR_CFG);
    wire wr_det = reg_wr_in && (reg_addr_in == pdr_pkg::ADDR_DET_EN);
    wire commit = good_end && !alert_ff;
    wire cr_commit = is_cable && !alert_ff && (state_ff == ST_IDLE);
    wire clr_len = hr_event || disconnect_in || rx_message_alert_clear_in;
    wire [7:0] pay_idx = reg_addr_in - pdr_pkg::ADDR_RX_PAYLOAD_FIRST;
    wire pay_hit = (reg_addr_in >= pdr_pkg::ADDR_RX_PAYLOAD_FIRST) && (reg_addr_in <= pdr_pkg::ADDR_RX_PAYLOAD_LAST);

    // Configuration registers; reserved bits never store
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hdr_cfg_ff <= pdr_pkg::HDR_CFG_RESET;
            det_en_ff <= pdr_pkg::DET_EN_RESET;
        end else begin
            if (wr_hdr) hdr_cfg_ff <= reg_wdata_in & pdr_pkg::HDR_CFG_WMASK;
            // Hard reset wins over a same-cycle write; disconnect does nothing here
            if (hr_event) det_en_ff <= pdr_pkg::DET_EN_RESET;
            else if (wr_det) det_en_ff <= reg_wdata_in & pdr_pkg::DET_EN_WMASK;
        end
    end

    // Sequencer state and per-frame counters
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_ff <= ST_IDLE;
            cur_kind_ff <= pdr_pkg::KIND_SOP;
            wcnt_ff <= 8'h00;
            dcnt_ff <= 8'h00;
            overflow_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (accept_start) begin
                cur_kind_ff <= rx_kind_in;
                dcnt_ff <= 8'h00;
                wcnt_ff <= 8'h00;
                overflow_ff <= 1'b0;
            end else if (f_pop) begin
                dcnt_ff <= dcnt_ff + 8'h01;
                if (dcnt_ff >= 8'(pdr_pkg::PAYLOAD_BYTES + 2)) overflow_ff <= 1'b1;
            end
            if (f_push) wcnt_ff <= wcnt_ff + 8'h01;
        end
    end

    // Staging for header bytes; payload array written in place
    always_ff @(posedge clk_in) begin
        if (f_pop && dcnt_ff == 8'h00) stg_lo_ff <= f_data;
        if (f_pop && dcnt_ff == 8'h01) stg_hi_ff <= f_data;
    end

    genvar gi;
    generate
        for (gi = 0; gi < pdr_pkg::PAYLOAD_BYTES; gi++) begin : g_pay
            always_ff @(posedge clk_in) begin
                if (rst_in) payload_ff[gi] <= pdr_pkg::RX_ZERO;
                else if (f_pop && dcnt_ff == 8'(gi + 2)) payload_ff[gi] <= f_data;
            end
        end
    endgenerate

    // Committed receive record; a message commit updates all four, a cable reset only count and kind
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rx_len_ff <= pdr_pkg::RX_ZERO;
            rx_kind_ff <= pdr_pkg::RX_ZERO;
            hdr_lo_ff <= pdr_pkg::RX_ZERO;
            hdr_hi_ff <= pdr_pkg::RX_ZERO;
        end else if (commit) begin
            rx_len_ff <= dcnt_ff + pdr_pkg::RX_OVERHEAD - 8'h02;
            rx_kind_ff <= {5'h00, cur_kind_ff};
            hdr_lo_ff <= stg_lo_ff;
            hdr_hi_ff <= stg_hi_ff;
        end else if (cr_commit) begin
            rx_len_ff <= pdr_pkg::RX_ZERO;
            rx_kind_ff <= {5'h00, pdr_pkg::KIND_CABLE_RESET};
        end else if (clr_len) begin
            rx_len_ff <= pdr_pkg::RX_ZERO;
        end
    end

    // Event flags: a new event wins over a same-cycle clear
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            alert_ff <= 1'b0;
            hr_seen_ff <= 1'b0;
            cr_seen_ff <= 1'b0;
        end else begin
            if (commit || cr_commit) alert_ff <= 1'b1;
            else if (rx_message_alert_clear_in || hr_event || disconnect_in) alert_ff <= 1'b0;
            hr_seen_ff <= is_hard;
            cr_seen_ff <= cr_commit;
        end
    end

    // Read mux; stale payload bytes still read back, software trims by count
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr_in)
            pdr_pkg::ADDR_HDR_CFG: rd_mux = hdr_cfg_ff;
            pdr_pkg::ADDR_DET_EN: rd_mux = det_en_ff;
            pdr_pkg::ADDR_RX_LEN: rd_mux = rx_len_ff;
            pdr_pkg::ADDR_RX_KIND: rd_mux = rx_kind_ff;
            pdr_pkg::ADDR_RX_HDR_LO: rd_mux = hdr_lo_ff;
            pdr_pkg::ADDR_RX_HDR_HI: rd_mux = hdr_hi_ff;
            default: rd_mux = pay_hit ? payload_ff[pay_idx[4:0]] : 8'h00;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) reg_rdata_out <= 8'h00;
        else if (reg_rd_in) reg_rdata_out <= rd_mux;
    end

    // Status outputs
    assign rx_message_alert_out = alert_ff;
    assign hard_reset_seen_out = hr_seen_ff;
    assign cable_reset_seen_out = cr_seen_ff;
    assign hdr_cfg_out = hdr_cfg_ff;
    assign det_en_out = det_en_ff;
    // Newer features stay on whatever revision is programmed
    assign fast_swap_supported_out = 1'b1;
    assign chunked_ext_supported_out = 1'b1;

    // Checks
    a_hr_clears_en: assert property (@(posedge clk_in) disable iff (rst_in)
        hr_event |=> det_en_ff == 8'h00) else $error("enables not cleared by hard reset");
    a_disc_keeps_en: assert property (@(posedge clk_in) disable iff (rst_in)
        disconnect_in && !hr_event && !wr_det |=> $stable(det_en_ff)) else $error("disconnect touched enables");
    a_len_cleared: assert property (@(posedge clk_in) disable iff (rst_in)
        clr_len && !commit && !cr_commit |=> rx_len_ff == 8'h00) else $error("count not cleared");
    a_alert_clr_len: assert property (@(posedge clk_in) disable iff (rst_in)
        rx_message_alert_clear_in && !commit |=> rx_len_ff == 8'h00) else $error("count kept after clear");
    a_len_plus_three: assert property (@(posedge clk_in) disable iff (rst_in)
        commit |=> rx_len_ff == $past(dcnt_ff) + 8'h01) else $error("count not payload plus three");
    a_kind_upper_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        rx_kind_ff[7:3] == 5'h00 && rx_kind_ff[2:0] != 3'h5 && rx_kind_ff[2:0] != 3'h7) else $error("bad kind");
    a_hdr_rsvd_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_hdr |=> hdr_cfg_ff[7:5] == 3'h0 && hdr_cfg_ff[4:0] == $past(reg_wdata_in[4:0])) else $error("hdr write");
    a_record_stable: assert property (@(posedge clk_in) disable iff (rst_in)
        !commit && !cr_commit |=> $stable(hdr_lo_ff) && $stable(hdr_hi_ff)) else $error("header moved");
    a_disabled_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
        rx_start_in && !kind_enabled |=> state_ff != ST_FRAME || $past(state_ff) == ST_FRAME) else $error("disabled kind taken");
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    typedef struct {logic wr; logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} pdr_row_t;
    logic clk_in, rst_in, reg_wr, reg_rd, rx_start, rx_valid, rx_ready, rx_end, rx_good;
    logic hr_rx, hr_tx, disc, alert_clr, alert, hr_seen, cr_seen, fast_swap, chunked;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_data, hdr_cfg, det_en, rd_val;
    logic [2:0] rx_kind;
    int bad_count, tests_run, i;
    int hr_cnt = 0;
    int cr_cnt = 0;
    pdr_row_t rows [13];

    pdr_rx_regs u_pdr_rx_regs (.clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .rx_start_in(rx_start),
        .rx_kind_in(rx_kind), .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_ready_out(rx_ready),
        .rx_end_in(rx_end), .rx_good_in(rx_good), .hard_reset_rx_in(hr_rx), .hard_reset_tx_in(hr_tx),
        .disconnect_in(disc), .rx_message_alert_clear_in(alert_clr), .rx_message_alert_out(alert),
        .hard_reset_seen_out(hr_seen), .cable_reset_seen_out(cr_seen), .hdr_cfg_out(hdr_cfg),
        .det_en_out(det_en), .fast_swap_supported_out(fast_swap), .chunked_ext_supported_out(chunked));
    pdr_phy_model u_pdr_phy_model (.clk_in(clk_in), .start_out(rx_start), .kind_out(rx_kind),
        .valid_out(rx_valid), .data_out(rx_data), .ready_in(rx_ready), .end_out(rx_end), .good_out(rx_good));

    // Free-running clock, 8 ns period
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    // One-cycle event pulses are counted so they can be compared later
    always @(posedge clk_in) begin
        if (hr_seen === 1'b1) hr_cnt++;
        if (cr_seen === 1'b1) cr_cnt++;
    end

    task chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Each access lets an edge pass first so strobes never toggle twice in a step
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_in);
        #1;
        reg_wr = 1'b0;
    endtask

    task rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge clk_in);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_in);
        #1;
        reg_rd = 1'b0;
        chk8(name, exp, reg_rdata);
    endtask

    task automatic pulse(ref logic s);
        @(posedge clk_in);
        #1;
        s = 1'b1;
        @(posedge clk_in);
        #1;
        s = 1'b0;
    endtask

    task wait_alert();
        int n;
        n = 0;
        while (alert !== 1'b1 && n < 200) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (n >= 200) begin
            bad_count++;
            $display("BAD alert never rose");
            stop_test();
        end
    endtask

    task stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        {reg_wr, reg_rd, hr_rx, hr_tx, disc, alert_clr} = 6'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        bad_count = 0;
        tests_run = 0;
        rst_in = 1'b1;
        rows = '{'{0, 8'h2e, 8'h00, 8'h02}, '{0, 8'h2f, 8'h00, 8'h00}, '{0, 8'h30, 8'h00, 8'h00},
                 '{0, 8'h31, 8'h00, 8'h00}, '{0, 8'h32, 8'h00, 8'h00}, '{0, 8'h33, 8'h00, 8'h00},
                 '{1, 8'h2e, 8'hff, 8'h1f}, '{1, 8'h2e, 8'h19, 8'h19}, '{1, 8'h2e, 8'h04, 8'h04},
                 '{1, 8'h2f, 8'hff, 8'h7f}, '{1, 8'h30, 8'h55, 8'h00}, '{1, 8'h60, 8'haa, 8'h00},
                 '{1, 8'h2f, 8'h01, 8'h01}};
        repeat (20) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        // Reset values, field masks, read-only and unmapped places
        for (i = 0; i < 13; i++) begin
            if (rows[i].wr) wr(rows[i].addr, rows[i].wdata);
            rdchk(rows[i].addr, rows[i].exp, "table read");
        end
        chk8("feature flags", 8'h03, {6'h00, fast_swap, chunked});
        // Enabled port message, slow partner, FIFO drains as bytes trickle in
        u_pdr_phy_model.send_frame(3'h0, 6, 8'h10, 1'b1, 2);
        wait_alert();
        rdchk(8'h30, 8'h07, "count");
        rdchk(8'h31, 8'h00, "kind");
        rdchk(8'h32, 8'h10, "hdr low");
        rdchk(8'h33, 8'h11, "hdr high");
        rdchk(8'h34, 8'h12, "payload");
        pulse(alert_clr);
        rdchk(8'h30, 8'h00, "count after clear");
        rdchk(8'h32, 8'h10, "hdr kept");
        // Disabled kind, then bad CRC: nothing may be committed
        for (i = 0; i < 2; i++) begin
            u_pdr_phy_model.send_frame(i[2:0] ^ 3'h1, 4 * i, 8'h40, 1'b0, 0);
            repeat (20) @(posedge clk_in);
            chk8("refused alert", 8'h00, {7'h00, alert});
        end
        rdchk(8'h32, 8'h10, "hdr not overwritten");
        wr(8'h2f, 8'h41);
        u_pdr_phy_model.send_frame(3'h6, 0, 8'h00, 1'b1, 0);
        wait_alert();
        rdchk(8'h31, 8'h06, "cable reset kind");
        chk8("cable reset pulses", 8'h01, 8'(cr_cnt));
        pulse(alert_clr);
        // Header-only frame, then detach
        u_pdr_phy_model.send_frame(3'h0, 2, 8'h70, 1'b1, 0);
        wait_alert();
        rdchk(8'h30, 8'h03, "short count");
        pulse(disc);
        rdchk(8'h30, 8'h00, "count after detach");
        chk8("enables after detach", 8'h41, det_en);
        wr(8'h2e, 8'h02);
        chk8("hdr cfg out", 8'h02, hdr_cfg);
        wr(8'h2f, 8'h00);
        // Hard reset received, then transmitted
        for (i = 0; i < 2; i++) begin
            pulse(alert_clr);
            wr(8'h2f, 8'h21);
            u_pdr_phy_model.send_frame(3'h0, 4, 8'h20, 1'b1, 0);
            wait_alert();
            if (i == 0) pulse(hr_rx);
            else pulse(hr_tx);
            chk8("enables after hard reset", 8'h00, det_en);
            rdchk(8'h30, 8'h00, "count after hard reset");
        end
        // Hard reset arriving on the stream itself
        chk8("hard reset pulses before", 8'h00, 8'(hr_cnt));
        wr(8'h2f, 8'h20);
        u_pdr_phy_model.send_frame(3'h5, 0, 8'h00, 1'b1, 0);
        repeat (2) @(posedge clk_in);
        #1;
        chk8("enables after stream hard reset", 8'h00, det_en);
        chk8("hard reset pulses", 8'h01, 8'(hr_cnt));
        chk8("partner stalls", 8'h00, 8'(u_pdr_phy_model.timeouts));
        stop_test();
    end
endmodule
`default_nettype wire
